// ---- src/ffmd_detector.sv ----
// freefall/motion event detector with debounce and source flags
// assumes sample_valid is a one-cycle strobe per output data sample,
// src_read is a one-cycle strobe from the register interface
`timescale 1ns/1ns
`default_nettype none
module ffmd_detector #(
    parameter int SAMPLE_WIDTH = ffmd_pkg::AXIS_WIDTH,
    parameter int THRESH_WIDTH = ffmd_pkg::THRESH_WIDTH
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire ffmd_pkg::ffmd_cfg_t detector_config_register,
    input wire logic debounce_counter_mode,
    input wire logic [7:0] debounce_count_register,
    input wire logic [THRESH_WIDTH-1:0] detection_threshold_register,
    input wire logic sample_valid,
    input wire logic [SAMPLE_WIDTH-1:0] sample_x,
    input wire logic [SAMPLE_WIDTH-1:0] sample_y,
    input wire logic [SAMPLE_WIDTH-1:0] sample_z,
    input wire logic src_read,
    output logic [7:0] event_source_register,
    output logic summary_event_flag
);

    // ************************************************************
    // per-axis comparison
    // ************************************************************
    wire logic en_x = detector_config_register.axis_x_event_enable;
    wire logic en_y = detector_config_register.axis_y_event_enable;
    wire logic en_z = detector_config_register.axis_z_event_enable;
    wire logic latch_on = detector_config_register.event_latch_on;
    wire logic motion_sel = detector_config_register.freefall_or_motion_select;
    wire logic any_enabled = en_x | en_y | en_z;

    logic high_x, high_y, high_z;
    logic low_x, low_y, low_z;
    logic neg_x, neg_y, neg_z;

    ffmd_axis_cmp #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .THRESH_WIDTH(THRESH_WIDTH)) u_cmp_x (
        .sample(sample_x),
        .threshold(detection_threshold_register),
        .enable(en_x),
        .high_g(high_x),
        .low_g(low_x),
        .negative(neg_x)
    );
    ffmd_axis_cmp #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .THRESH_WIDTH(THRESH_WIDTH)) u_cmp_y (
        .sample(sample_y),
        .threshold(detection_threshold_register),
        .enable(en_y),
        .high_g(high_y),
        .low_g(low_y),
        .negative(neg_y)
    );
    ffmd_axis_cmp #(.SAMPLE_WIDTH(SAMPLE_WIDTH), .THRESH_WIDTH(THRESH_WIDTH)) u_cmp_z (
        .sample(sample_z),
        .threshold(detection_threshold_register),
        .enable(en_z),
        .high_g(high_z),
        .low_g(low_z),
        .negative(neg_z)
    );

    // ************************************************************
    // summary condition
    // ************************************************************
    // disabled axis counts as true for AND, false for OR
    wire logic ff_cond = (low_x | ~en_x) & (low_y | ~en_y) & (low_z | ~en_z);
    wire logic mt_cond = high_x | high_y | high_z;
    wire logic condition = any_enabled & (motion_sel ? mt_cond : ff_cond);

    // raw axis flags: event is high-g for motion, low-g for freefall
    wire logic raw_ev_x = motion_sel ? high_x : low_x;
    wire logic raw_ev_y = motion_sel ? high_y : low_y;
    wire logic raw_ev_z = motion_sel ? high_z : low_z;
    wire ffmd_pkg::ffmd_axis_flags_t raw_x = '{raw_ev_x, neg_x & raw_ev_x};
    wire ffmd_pkg::ffmd_axis_flags_t raw_y = '{raw_ev_y, neg_y & raw_ev_y};
    wire ffmd_pkg::ffmd_axis_flags_t raw_z = '{raw_ev_z, neg_z & raw_ev_z};
    wire logic [7:0] raw_src = {1'b0, 1'b0, raw_z, raw_y, raw_x};
    wire logic [7:0] enable_mask = {1'b1, 1'b0, {2{en_z}}, {2{en_y}}, {2{en_x}}};

    // ************************************************************
    // debounce counter
    // ************************************************************
    logic [7:0] debounce_count;
    logic summary;
    logic [7:0] axis_hold;

    wire logic latched_clear = latch_on & src_read;
    wire logic at_target = (debounce_count >= debounce_count_register);
    wire logic frozen = latch_on & summary;

    logic [7:0] next_count;
    always_comb
    begin
        next_count = debounce_count;
        if (latched_clear | ~any_enabled)
        begin
            next_count = 8'h00;
        end
        else if (sample_valid & ~frozen)
        begin
            if (condition)
            begin
                if (!at_target)
                begin
                    next_count = debounce_count + 8'h01;
                end
            end
            else if (debounce_counter_mode)
            begin
                next_count = 8'h00;
            end
            else if (debounce_count != 8'h00)
            begin
                next_count = debounce_count - 8'h01;
            end
        end
    end

    // qualify on equality with the programmed count
    wire logic next_at_target = (next_count == debounce_count_register);
    logic next_summary;
    always_comb
    begin
        next_summary = summary;
        if (latched_clear | ~any_enabled)
        begin
            next_summary = 1'b0;
        end
        else if (latch_on)
        begin
            if (sample_valid & condition & next_at_target)
            begin
                next_summary = 1'b1;
            end
        end
        else if (sample_valid)
        begin
            if (condition)
            begin
                next_summary = summary | next_at_target;
            end
            else if (debounce_counter_mode)
            begin
                next_summary = 1'b0;
            end
            else
            begin
                next_summary = summary & (next_count != 8'h00);
            end
        end
    end

    // ************************************************************
    // source flags
    // ************************************************************
    localparam logic [7:0] SRC_CLEAR = ffmd_pkg::SRC_RESET;
    logic [7:0] next_axis;
    always_comb
    begin
        next_axis = axis_hold;
        if (~any_enabled | latched_clear)
        begin
            next_axis = SRC_CLEAR;
        end
        else if (~frozen & sample_valid)
        begin
            next_axis = raw_src;
        end
    end

    wire logic [7:0] next_source = ({next_summary, 1'b0, next_axis[5:0]}) & enable_mask;

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            debounce_count <= ffmd_pkg::COUNT_RESET;
            summary <= 1'b0;
            axis_hold <= ffmd_pkg::SRC_RESET;
            event_source_register <= ffmd_pkg::SRC_RESET;
            summary_event_flag <= 1'b0;
        end
        else
        begin
            debounce_count <= next_count;
            summary <= next_summary;
            axis_hold <= next_axis;
            event_source_register <= next_source;
            summary_event_flag <= next_summary;
        end
    end

endmodule : ffmd_detector
`default_nettype wire

// ---- src/ffmd_pkg.sv ----
// package for the freefall/motion event detector
// assumes one system clock and a sample strobe from the data path
package ffmd_pkg;

    // ************************************************************
    // register map of the detector
    // ************************************************************
    localparam logic [7:0] CFG_ADDR = 8'h15;
    localparam logic [7:0] SRC_ADDR = 8'h16;
    localparam int CFG_LATCH_BIT = 7;
    localparam int CFG_SELECT_BIT = 6;
    localparam int CFG_Z_EN_BIT = 5;
    localparam int CFG_Y_EN_BIT = 4;
    localparam int CFG_X_EN_BIT = 3;
    localparam int SRC_SUMMARY_BIT = 7;
    localparam int SRC_Z_EVENT_BIT = 5;
    localparam int SRC_Z_POL_BIT = 4;
    localparam int SRC_Y_EVENT_BIT = 3;
    localparam int SRC_Y_POL_BIT = 2;
    localparam int SRC_X_EVENT_BIT = 1;
    localparam int SRC_X_POL_BIT = 0;

    // ************************************************************
    // reset values and data widths
    // ************************************************************
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] SRC_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic DBCNT_MODE_RESET = 1'b1;
    localparam int AXIS_WIDTH = 12;
    localparam int THRESH_WIDTH = 7;

    typedef struct packed {
        logic event_flag;
        logic polarity_flag;
    } ffmd_axis_flags_t;

    typedef struct packed {
        logic event_latch_on;
        logic freefall_or_motion_select;
        logic axis_z_event_enable;
        logic axis_y_event_enable;
        logic axis_x_event_enable;
    } ffmd_cfg_t;

endpackage : ffmd_pkg

// ---- src/ffmd_axis_cmp.sv ----
// one axis threshold comparison
// assumes two's complement sample, unsigned threshold against top bits
`timescale 1ns/1ns
`default_nettype none
module ffmd_axis_cmp #(
    parameter int SAMPLE_WIDTH = ffmd_pkg::AXIS_WIDTH,
    parameter int THRESH_WIDTH = ffmd_pkg::THRESH_WIDTH
) (
    input wire logic [SAMPLE_WIDTH-1:0] sample,
    input wire logic [THRESH_WIDTH-1:0] threshold,
    input wire logic enable,
    output logic high_g,
    output logic low_g,
    output logic negative
);
    wire logic sign_bit = sample[SAMPLE_WIDTH-1];
    wire logic [SAMPLE_WIDTH-1:0] magnitude_full = sign_bit ? (~sample + 1'b1) : sample;
    // magnitude in threshold steps: drop the lower bits
    wire logic [SAMPLE_WIDTH-1:0] magnitude_step = magnitude_full >> (SAMPLE_WIDTH - 1 - THRESH_WIDTH);
    wire logic [SAMPLE_WIDTH-1:0] thresh_wide = {{(SAMPLE_WIDTH-THRESH_WIDTH){1'b0}}, threshold};
    assign high_g = enable & (magnitude_step > thresh_wide);
    assign low_g = enable & (magnitude_step <= thresh_wide);
    assign negative = enable & sign_bit;
endmodule : ffmd_axis_cmp
`default_nettype wire

// ---- tb/ffmd_detector_properties.sv ----
// port checker for the freefall/motion detector
// assumes one clock and an async active-low reset
`timescale 1ns/1ns
`default_nettype none
module ffmd_detector_properties (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire ffmd_pkg::ffmd_cfg_t detector_config_register,
    input wire logic sample_valid,
    input wire logic src_read,
    input wire logic [7:0] event_source_register,
    input wire logic summary_event_flag
);
    // ****************
    // port relations
    // ****************
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    wire [7:0] esr = event_source_register;
    wire latch = detector_config_register.event_latch_on;
    wire any_en = |detector_config_register[2:0];
    wire held = latch && summary_event_flag;
    AST_MIRROR: assert property (summary_event_flag == esr[7])
        else $error("summary differs from bit 7");
    AST_OFF: assert property (!any_en |=> esr == 8'h00)
        else $error("disabled detector not clear");
    AST_X_GATE: assert property (sample_valid && !held && !detector_config_register[0]
        |=> esr[1:0] == 2'h0) else $error("disabled x flags set");
    AST_RD_KEEP: assert property (any_en && !latch && src_read && !sample_valid
        |=> $stable(esr)) else $error("read changed flags");
    AST_RD_CLR: assert property (latch && src_read |=> esr == 8'h00)
        else $error("read did not clear");
    AST_HOLD: assert property (any_en && held && !src_read |=> $stable(esr))
        else $error("latched flags moved");
    AST_IDLE: assert property (any_en && !sample_valid && !src_read |=> $stable(esr))
        else $error("flags moved without sample");
    AST_SET: assert property ($rose(summary_event_flag) |-> $past(sample_valid))
        else $error("summary set without sample");
    COV_LATCH: cover property (latch && $rose(summary_event_flag));
    COV_MOTION: cover property (detector_config_register[3] && $rose(summary_event_flag));
    COV_CLEAR: cover property (held && src_read);
endmodule : ffmd_detector_properties
bind ffmd_detector ffmd_detector_properties ffmd_detector_properties_inst (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .detector_config_register(detector_config_register),
    .sample_valid(sample_valid), .src_read(src_read),
    .event_source_register(event_source_register),
    .summary_event_flag(summary_event_flag)
);
`default_nettype wire

// ---- tb/ffmd_host_model.sv ----
// host side: reads the event source register
// assumes a one-cycle read strobe taken at a rising edge
`timescale 1ns/1ns
`default_nettype none
module ffmd_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] event_source_register,
    output var logic src_read
);
    // ****************
    // register read
    // ****************
    initial src_read = 1'b0;
    task automatic read_reg(output logic [7:0] value);
        @(negedge sys_clk);
        src_read = 1'b1;
        value = event_source_register;
        @(posedge sys_clk);
        @(negedge sys_clk);
        src_read = 1'b0;
    endtask : read_reg
endmodule : ffmd_host_model
`default_nettype wire

// ---- tb/test_freefall_motion_event_detector.sv ----
// self-checking bench for the detector
// assumes the host model and the bound checker
`timescale 1ns/1ns
`default_nettype none
module test_freefall_motion_event_detector;
    logic sys_clk, reset_n, dbm, sv, summ, src_read;
    ffmd_pkg::ffmd_cfg_t cfg;
    logic [7:0] cnt_reg, esr, m_esr, rv;
    logic [6:0] ths;
    logic [11:0] sx, sy, sz, c;
    int err_count, checked, cycles, m_cnt;
    ffmd_detector ffmd_detector_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .detector_config_register(cfg),
        .debounce_counter_mode(dbm), .debounce_count_register(cnt_reg),
        .detection_threshold_register(ths), .sample_valid(sv), .sample_x(sx),
        .sample_y(sy), .sample_z(sz), .src_read(src_read),
        .event_source_register(esr), .summary_event_flag(summ)
    );
    ffmd_host_model ffmd_host_model_inst (
        .sys_clk(sys_clk), .event_source_register(esr), .src_read(src_read)
    );
    // ****************
    // clock, checks, model
    // ****************
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic compare8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : compare8
    function automatic logic [1:0] axf(input logic [11:0] s, input logic en);
        int mag;
        logic ev;
        mag = $signed(s);
        mag = (mag < 0 ? -mag : mag) / 16;
        ev = en && (cfg.freefall_or_motion_select ? mag > int'(ths) : mag <= int'(ths));
        return {ev, ev & s[11]};
    endfunction : axf
    task automatic step(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
        logic [1:0] fx, fy, fz;
        logic sum;
        @(negedge sys_clk);
        {sv, sx, sy, sz} = {1'b1, x, y, z};
        @(negedge sys_clk);
        sv = 1'b0;
        fx = axf(x, cfg.axis_x_event_enable);
        fy = axf(y, cfg.axis_y_event_enable);
        fz = axf(z, cfg.axis_z_event_enable);
        sum = m_esr[7];
        if (cfg[2:0] == 3'h0)
            {m_esr, m_cnt} = 0;
        else if (!(cfg.event_latch_on && sum))
        begin
            if (cfg.freefall_or_motion_select ? |{fx[1], fy[1], fz[1]}
                : &({fz[1], fy[1], fx[1]} | ~cfg[2:0]))
            begin
                m_cnt += (m_cnt < cnt_reg);
                sum = sum | (m_cnt >= cnt_reg);
            end
            else
            begin
                m_cnt = dbm ? 0 : m_cnt - (m_cnt > 0);
                sum = !dbm && sum && m_cnt != 0;
            end
            m_esr = {sum, 1'b0, fz, fy, fx};
        end
        compare8(esr, m_esr);
        compare8({7'h00, summ}, {7'h00, m_esr[7]});
    endtask : step
    task automatic host_read();
        ffmd_host_model_inst.read_reg(rv);
        compare8(rv, m_esr);
        if (cfg.event_latch_on)
            {m_esr, m_cnt} = 0;
        compare8(esr, m_esr);
    endtask : host_read
    function automatic logic [11:0] pick();
        int v;
        v = int'(ths) * 16 + int'($urandom_range(0, 48)) - 24;
        v = v < 0 ? 0 : (v > 2047 ? 2047 : v);
        return $urandom_range(0, 1) ? 12'(-v) : 12'(v);
    endfunction : pick
    initial
    begin
        {reset_n, sv, sx, sy, sz, cfg, dbm, cnt_reg, ths} = 0;
        void'($urandom(32'hDBE6));
        for (int m = 0; m < 16; m++)
        begin
            reset_n = 1'b0;
            cfg = {m[0], m[1], m == 15 ? 3'h0 : 3'($urandom_range(1, 7))};
            dbm = m[2];
            cnt_reg = 8'($urandom_range(1, 3));
            ths = 7'($urandom_range(1, 120));
            {m_esr, m_cnt} = 0;
            c = m[1] ? 12'h801 : 12'h000;
            repeat (2) @(negedge sys_clk);
            reset_n = 1'b1;
            compare8(esr, 8'h00);
            repeat (3) step(c, c, c);
            repeat (40)
            begin
                if ($urandom_range(0, 7) == 0)
                    host_read();
                else
                    step(pick(), pick(), pick());
            end
        end
        stop_test();
    end
endmodule : test_freefall_motion_event_detector
`default_nettype wire
